// File: hdl/spics_control.sv
// Purpose: Control/status register of the serial port, flags and select pin
// Assumes: Shift engine and interrupt controller share mclk
// Notes:   Register read data appears one cycle after the read strobe
//
// How it works
// - Transfer-done flag bit 7 sets at every transfer end, master or slave.
// - Hardware never clears the four event flags; software must clear them.
// - Any set event flag raises interrupt request while port interrupts enabled.
// - Data write while transmit buffer not empty sets collision flag bit 6.
// - A colliding data write is dropped; transmit buffer stays unchanged.
// - Mode fault bit 5 sets on select low, master, mode field 01.
// - Slave overrun bit 4 sets when last bit arrives and receive buffer full.
// - Mode field 00 gives three-wire operation; select not routed to pin.
// - Mode field 01, the default, makes the select pin an input.
// - Mode field 1x drives select pin with the field's low bit.
// - Writing the transmit buffer clears buffer-empty status bit 1.
// - Moving buffer into shift register sets buffer-empty status.
// - Enable bit 0 low disables the port; high lets it operate.
// - Control register sits at address f8, with single-bit access.
// - Master-enable set selects master operation, clear selects slave.
// - In master operation a data write loads buffer and starts transfer.
`timescale 1ns/100ps
`default_nettype none
module spics_control (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire spics_pkg::spics_sfr_t sfr,
  input  wire spics_pkg::spics_evt_t evt,
  input  wire logic                 master_enable,
  input  wire logic                 int_enable,
  input  wire logic                 slave_select_line_in,
  output logic                      slave_select_line_out,
  output logic                      slave_select_line_oe,
  output logic [7:0]                sfr_rdata_ff,
  output logic                      sfr_rvalid_ff,
  output logic [7:0]                tx_data_ff,
  output logic                      tx_write_ff,
  output logic                      xfer_start_ff,
  output logic                      port_on_ff,
  output logic                      master_mode_ff,
  output logic                      slave_selected_ff,
  output logic                      irq_ff
);

  logic [3:0] flags_ff;
  logic [3:0] nxt_flags;
  logic [3:0] flag_set;
  logic [1:0] mode_ff;
  logic       tx_buffer_empty_ff;
  logic       enable_ff;
  logic       ss_sync;
  logic       ss_low;
  logic       byte_wr;
  logic       bit_hit;
  logic       data_wr;
  logic       data_ok;
  logic       data_coll;
  logic [7:0] ctrl_view;
  logic [7:0] wr_image;

  spics_sync #(
    .WIDTH    (1),
    .INIT_VAL (1'h1)
  ) u_ss_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (slave_select_line_in),
    .sync_ff  (ss_sync)
  );

  assign ss_low    = !ss_sync;
  assign byte_wr   = sfr.wr && (sfr.addr == spics_pkg::CTRL_ADDR);
  assign bit_hit   = sfr.bit_wr && (sfr.bit_addr[7:3] == spics_pkg::CTRL_ADDR[7:3]);
  assign data_wr   = sfr.wr && (sfr.addr == spics_pkg::DATA_ADDR);
  assign data_coll = data_wr && !tx_buffer_empty_ff;
  assign data_ok   = data_wr && tx_buffer_empty_ff;

  assign ctrl_view = {flags_ff, mode_ff, tx_buffer_empty_ff, enable_ff};

  // Byte write or single-bit write merged into one image of the register
  always_comb begin
    wr_image = ctrl_view;
    if (byte_wr) begin
      wr_image = sfr.wdata;
    end else if (bit_hit) begin
      wr_image[sfr.bit_addr[2:0]] = sfr.bit_val;
    end
  end

  // Hardware events, indexed as flags_ff: 3 done, 2 collision, 1 fault, 0 overrun
  always_comb begin
    flag_set[3] = evt.xfer_done;
    flag_set[2] = data_coll;
    flag_set[1] = enable_ff && ss_low && master_enable
                  && (mode_ff == spics_pkg::MODE_4WIRE_IN);
    flag_set[0] = !master_enable && evt.last_bit && evt.rx_full;
  end

  // Set wins over a clear landing in the same cycle; nothing else clears
  always_comb begin
    nxt_flags = flags_ff;
    if (byte_wr || bit_hit) begin
      nxt_flags = wr_image[spics_pkg::DONE_BIT -: 4];
    end
    nxt_flags = nxt_flags | flag_set;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_ff <= spics_pkg::CTRL_RESET[7:4];
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_ff   <= spics_pkg::CTRL_RESET[3:2];
      enable_ff <= spics_pkg::CTRL_RESET[0];
    end else if (byte_wr || bit_hit) begin
      mode_ff   <= wr_image[spics_pkg::MODE_LSB +: 2];
      enable_ff <= wr_image[spics_pkg::ENABLE_BIT];
    end
  end

  // A write in the same cycle as a buffer move still leaves fresh data pending
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_buffer_empty_ff <= spics_pkg::CTRL_RESET[1];
    end else if (data_ok) begin
      tx_buffer_empty_ff <= 1'b0;
    end else if (evt.tx_load) begin
      tx_buffer_empty_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_data_ff    <= 8'h00;
      tx_write_ff   <= 1'b0;
      xfer_start_ff <= 1'b0;
    end else begin
      tx_write_ff   <= data_ok;
      xfer_start_ff <= data_ok && enable_ff && master_enable;
      if (data_ok) begin
        tx_data_ff <= sfr.wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      port_on_ff     <= 1'b0;
      master_mode_ff <= 1'b0;
    end else begin
      port_on_ff     <= enable_ff;
      master_mode_ff <= enable_ff && master_enable;
    end
  end

  // Three-wire slaves count as selected whenever enabled, since no select pin exists
  always_ff @(posedge mclk) begin
    if (rst) begin
      slave_select_line_out <= 1'b1;
      slave_select_line_oe  <= 1'b0;
      slave_selected_ff     <= 1'b0;
    end else begin
      slave_select_line_out <= mode_ff[0];
      slave_select_line_oe  <= mode_ff[1];
      case (mode_ff)
        spics_pkg::MODE_3WIRE:    slave_selected_ff <= enable_ff;
        spics_pkg::MODE_4WIRE_IN: slave_selected_ff <= enable_ff && ss_low;
        default:                  slave_selected_ff <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= int_enable && (|flags_ff);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata_ff  <= 8'h00;
      sfr_rvalid_ff <= 1'b0;
    end else begin
      sfr_rvalid_ff <= sfr.rd && (sfr.addr == spics_pkg::CTRL_ADDR);
      if (sfr.rd && (sfr.addr == spics_pkg::CTRL_ADDR)) begin
        sfr_rdata_ff <= ctrl_view;
      end
    end
  end

  done_flag_set_a: assert property (@(posedge mclk) disable iff (rst)
    evt.xfer_done |=> flags_ff[3])
    else $error("transfer done flag not set");

  flags_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (|flags_ff) && !byte_wr && !bit_hit |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("event flag cleared by hardware");

  irq_raise_a: assert property (@(posedge mclk) disable iff (rst)
    int_enable && (|flags_ff) |=> irq_ff)
    else $error("interrupt not raised");

  write_collision_flag_set_a: assert property (@(posedge mclk) disable iff (rst)
    data_wr && !tx_buffer_empty_ff |=> flags_ff[2])
    else $error("collision flag not set");

  write_collision_flag_drop_a: assert property (@(posedge mclk) disable iff (rst)
    data_wr && !tx_buffer_empty_ff |=> $stable(tx_data_ff) && !tx_write_ff)
    else $error("colliding write reached buffer");

  mode_fault_a: assert property (@(posedge mclk) disable iff (rst)
    enable_ff && ss_low && master_enable && mode_ff == 2'h1 |=> flags_ff[1])
    else $error("mode fault not flagged");

  overrun_set_a: assert property (@(posedge mclk) disable iff (rst)
    !master_enable && evt.last_bit && evt.rx_full |=> flags_ff[0])
    else $error("overrun not flagged");

  pin_unrouted_a: assert property (@(posedge mclk) disable iff (rst)
    mode_ff == 2'h0 ##1 mode_ff == 2'h0 |-> !slave_select_line_oe)
    else $error("select pin driven in three-wire mode");

  pin_input_a: assert property (@(posedge mclk) disable iff (rst)
    mode_ff == 2'h1 |=> !slave_select_line_oe)
    else $error("select pin driven in input mode");

  pin_output_a: assert property (@(posedge mclk) disable iff (rst)
    mode_ff[1] |=> slave_select_line_oe && slave_select_line_out == $past(mode_ff[0]))
    else $error("select pin output wrong");

  tx_buffer_empty_clear_a: assert property (@(posedge mclk) disable iff (rst)
    data_wr && tx_buffer_empty_ff |=> !tx_buffer_empty_ff ##1 tx_write_ff == 1'b0)
    else $error("buffer empty not cleared");

  tx_buffer_empty_set_a: assert property (@(posedge mclk) disable iff (rst)
    evt.tx_load && !data_wr |=> tx_buffer_empty_ff)
    else $error("buffer empty not set");

  start_master_a: assert property (@(posedge mclk) disable iff (rst)
    data_wr && tx_buffer_empty_ff && enable_ff && master_enable |=> xfer_start_ff && tx_write_ff)
    else $error("master write did not start transfer");

endmodule : spics_control
`default_nettype wire

// File: hdl/spics_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Destination runs on mclk
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module spics_sync #(
  parameter int         WIDTH    = 1,
  parameter logic [0:0] INIT_VAL = 1'h1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_ff
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_ff <= {WIDTH{INIT_VAL}};
      sync_ff <= {WIDTH{INIT_VAL}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

endmodule : spics_sync
`default_nettype wire

// File: pkg/spics_pkg.sv
// Purpose: Shared constants and carriers for the serial port control/status block
// Assumes: Special-function bus and shift engine run on the system clock
// Notes:   Register offsets are special-function addresses
package spics_pkg;

  localparam logic [7:0] CTRL_ADDR     = 8'hf8;
  localparam logic [7:0] DATA_ADDR     = 8'ha3;
  localparam logic [7:0] CTRL_RESET    = 8'h06;
  localparam int         DONE_BIT      = 7;
  localparam int         WRITE_COLLISION_FLAG_BIT      = 6;
  localparam int         MODE_FAULT_FLAG_BIT      = 5;
  localparam int         OVRN_BIT      = 4;
  localparam int         MODE_LSB      = 2;
  localparam int         TX_BUFFER_EMPTY_BIT     = 1;
  localparam int         ENABLE_BIT    = 0;
  localparam logic [1:0] MODE_3WIRE    = 2'h0;
  localparam logic [1:0] MODE_4WIRE_IN = 2'h1;
  localparam int         SYNC_STAGES   = 2;

  // Special-function bus request, byte and single-bit access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [7:0] bit_addr;
    logic       bit_val;
  } spics_sfr_t;

  // One-cycle events from the shift engine, plus receive buffer level
  typedef struct packed {
    logic xfer_done;
    logic last_bit;
    logic rx_full;
    logic tx_load;
  } spics_evt_t;

endpackage : spics_pkg

// File: sim/spics_far_end.sv
// Purpose: Far-side model of the select wire, another master sharing it
// Assumes: Wire has a pull-up, so a released line reads high
// Notes:   The bench commands when the other master pulls the line low
`timescale 1ns/100ps
`default_nettype none
module spics_far_end (
  input  wire logic drive_low,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output var  logic pin
);
  // Device drive wins; otherwise the other master or the pull-up sets the level
  always_comb begin
    if (dev_oe) begin
      pin = dev_out;
    end else begin
      pin = drive_low ? 1'h0 : 1'h1;
    end
  end
endmodule : spics_far_end
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the serial port control/status register
// Assumes: Strobes are driven on the falling edge and held one cycle
// Notes:   Flags are cleared between scenarios by writes of 0
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                  mclk;
  logic                  rst;
  spics_pkg::spics_sfr_t sfr;
  spics_pkg::spics_evt_t evt;
  logic                  master_enable;
  logic                  int_enable;
  logic                  drive_low;
  logic                  ss_pin;
  logic                  ss_out;
  logic                  ss_oe;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic [7:0]            tx_data;
  logic                  tx_write;
  logic                  xfer_start;
  logic                  port_on;
  logic                  master_mode;
  logic                  irq;
  logic                  selected;
  logic [7:0]            got;
  logic                  got_v;
  logic [1:0]            m;
  int                    n_mismatch;
  int                    n_tests;

  spics_control dut (
    .mclk                  (mclk),
    .rst                   (rst),
    .sfr                   (sfr),
    .evt                   (evt),
    .master_enable         (master_enable),
    .int_enable            (int_enable),
    .slave_select_line_in  (ss_pin),
    .slave_select_line_out (ss_out),
    .slave_select_line_oe  (ss_oe),
    .sfr_rdata_ff          (rdata),
    .sfr_rvalid_ff         (rvalid),
    .tx_data_ff            (tx_data),
    .tx_write_ff           (tx_write),
    .xfer_start_ff         (xfer_start),
    .port_on_ff            (port_on),
    .master_mode_ff        (master_mode),
    .slave_selected_ff     (selected),
    .irq_ff                (irq)
  );

  spics_far_end far (
    .drive_low (drive_low),
    .dev_out   (ss_out),
    .dev_oe    (ss_oe),
    .pin       (ss_pin)
  );

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task finish_test;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // Read data is captured one edge after the strobe is taken
  task bus(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr.rd = r;
    sfr.wr = w;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge mclk);
    got = rdata;
    got_v = rvalid;
    sfr.rd = 1'h0;
    sfr.wr = 1'h0;
  endtask : bus

  task rd_chk(input logic [7:0] exp);
    bus(1'h1, 1'h0, spics_pkg::CTRL_ADDR, 8'h00);
    chk({7'h0, got_v}, 8'h01);
    chk(got, exp);
  endtask : rd_chk

  task bitw(input logic [7:0] a, input logic v);
    @(negedge mclk);
    sfr.bit_wr = 1'h1;
    sfr.bit_addr = a;
    sfr.bit_val = v;
    @(negedge mclk);
    sfr.bit_wr = 1'h0;
  endtask : bitw

  // Mask order: done, last bit, receive full, transmit load
  task pulse(input logic [3:0] k);
    @(negedge mclk);
    evt = spics_pkg::spics_evt_t'(evt | k);
    @(negedge mclk);
    evt = spics_pkg::spics_evt_t'(evt & ~k);
  endtask : pulse

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    finish_test;
  end

  initial begin
    rst = 1'h1;
    sfr = '0;
    evt = '0;
    master_enable = 1'h0;
    int_enable = 1'h0;
    drive_low = 1'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    rd_chk(8'h06);
    chk({6'h0, ss_oe, ss_out}, 8'h01);
    bus(1'h1, 1'h0, 8'h00, 8'h00);
    chk({7'h0, got_v}, 8'h00);
    master_enable = 1'h1;
    int_enable = 1'h1;
    bus(1'h0, 1'h1, spics_pkg::CTRL_ADDR, 8'h05);
    idle(1);
    chk({6'h0, port_on, master_mode}, 8'h03);
    rd_chk(8'h07);
    bus(1'h0, 1'h1, spics_pkg::DATA_ADDR, 8'h55);
    chk(tx_data, 8'h55);
    chk({6'h0, tx_write, xfer_start}, 8'h03);
    rd_chk(8'h05);
    bus(1'h0, 1'h1, spics_pkg::DATA_ADDR, 8'haa);
    chk({7'h0, tx_write}, 8'h00);
    chk(tx_data, 8'h55);
    rd_chk(8'h45);
    pulse(4'h1);
    rd_chk(8'h47);
    pulse(4'h8);
    idle(1);
    chk({7'h0, irq}, 8'h01);
    rd_chk(8'hc7);
    idle(10);
    rd_chk(8'hc7);
    bitw(8'hff, 1'h0);
    rd_chk(8'h47);
    bitw(8'hfe, 1'h0);
    rd_chk(8'h07);
    chk({7'h0, irq}, 8'h00);
    drive_low = 1'h1;
    idle(5);
    rd_chk(8'h27);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, selected}, 8'h01);
    drive_low = 1'h0;
    master_enable = 1'h0;
    evt.rx_full = 1'h1;
    pulse(4'h4);
    rd_chk(8'h37);
    chk({7'h0, master_mode}, 8'h00);
    evt.rx_full = 1'h0;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      bus(1'h0, 1'h1, spics_pkg::CTRL_ADDR, {4'h0, m, 2'h1});
      idle(1);
      chk({5'h0, selected, ss_oe, ss_out & ss_oe}, {5'h0, m == 2'h0, m[1], m[1] & m[0]});
    end
    rd_chk(8'h0f);
    chk({7'h0, irq}, 8'h00);
    master_enable = 1'h1;
    bus(1'h0, 1'h1, spics_pkg::CTRL_ADDR, 8'h04);
    bus(1'h0, 1'h1, spics_pkg::DATA_ADDR, 8'h3c);
    chk({6'h0, port_on, xfer_start}, 8'h00);
    finish_test;
  end
endmodule : tb
`default_nettype wire
